//--- design/nhisp_pkg.sv
package nhisp_pkg;

  // Fixed upper five bits of the 7-bit slave address
  localparam logic [4:0] NHISP_ADDR_HEADER = 5'h0a;
  // Bits in one byte, counted on the serial clock
  localparam logic [3:0] NHISP_BYTE_BITS = 4'h8;
  // Data path and buffer shape
  localparam int NHISP_DATA_W = 8;
  localparam int NHISP_FIFO_DEPTH = 4;
  // Supported serial clock rates, in Hz, and the sampling clock
  localparam int NHISP_SCL_STD_HZ = 100000;
  localparam int NHISP_SCL_FAST_HZ = 400000;
  localparam int NHISP_SCL_HS_HZ = 3400000;
  localparam int NHISP_CLK_HZ = 50000000;
  // Shortest serial clock half period in system cycles, rounded down
  localparam int NHISP_HS_HALF_CYC = NHISP_CLK_HZ / (2 * NHISP_SCL_HS_HZ);

  // One received byte with a marker for the first byte after the address
  typedef struct packed {
    logic first;
    logic [NHISP_DATA_W-1:0] data;
  } nhisp_rx_s;

  localparam int NHISP_RX_W = $bits(nhisp_rx_s);

  // Transfer states, one-hot
  typedef enum logic [8:0] {
    ST_IDLE     = 9'h001,
    ST_ADDR     = 9'h002,
    ST_ADDR_ACK = 9'h004,
    ST_WR_DATA  = 9'h008,
    ST_WR_HOLD  = 9'h010,
    ST_WR_ACK   = 9'h020,
    ST_RD_LOAD  = 9'h040,
    ST_RD_DATA  = 9'h080,
    ST_RD_ACK   = 9'h100
  } nhisp_state_e;

endpackage

//--- design/nhisp_fifo.sv
`timescale 1ns/1ps
module nhisp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;

  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  wire [AW:0] depth_w = (AW+1)'(DEPTH);

  // Honest flags straight from the occupancy count
  assign in_ready = (count != depth_w);
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  // Storage has no reset; only pointers and the count carry control state
  always_ff @(posedge CLK) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers wrap on a power-of-two depth
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
      if (push && !pop) count <= count + 1'b1;
      else if (pop && !push) count <= count - 1'b1;
    end
  end

endmodule // nhisp_fifo

//--- design/nhisp_slave.sv
`timescale 1ns/1ps
// Functional notes
// - Slave only, bit rates up to 3.4 MBaud
// - Standard, fast and high-speed clock rates
// - Own address wakes port, others never
// - Notification line with programmable active level
// - Hold clock low to stall transfers
// - No general call, 10-bit, fast-plus
// - Own shift register, timing, address match
// - Address 01010 plus two straps, then R/W
// - Pins work only when bus selected
// - Wake moves standby device to active
module nhisp_slave
  import nhisp_pkg::*;
(
  // System
  input wire logic CLK,
  input wire logic RSTN,
  // Serial bus pins, split into input, output and enable
  input wire logic SERIAL_CLOCK_PIN_I,
  output logic SERIAL_CLOCK_PIN_O,
  output logic SERIAL_CLOCK_PIN_OE,
  input wire logic SERIAL_DATA_PIN_I,
  output logic SERIAL_DATA_PIN_O,
  output logic SERIAL_DATA_PIN_OE,
  // Address straps and bus selection
  input wire logic ADDR_STRAP_BIT0,
  input wire logic ADDR_STRAP_BIT1,
  input wire logic BUS_SELECT,
  // Notification line to the host
  input wire logic NOTIFY_ACTIVE_HIGH,
  output logic NOTIFY_PIN,
  // Power state
  input wire logic STANDBY_REQ,
  output logic WAKE,
  output logic ACTIVE,
  // Received bytes toward the device core
  output logic RX_VALID,
  input wire logic RX_READY,
  output logic RX_FIRST,
  output logic [NHISP_DATA_W-1:0] RX_DATA,
  // Bytes for the host to read
  input wire logic TX_VALID,
  output logic TX_READY,
  input wire logic [NHISP_DATA_W-1:0] TX_DATA
);

  logic [2:0] scl_s;
  logic [2:0] sda_s;
  logic scl_f;
  logic sda_f;
  logic scl_p;
  logic sda_p;
  logic [1:0] strap;
  logic strap_done;
  nhisp_state_e state;
  logic [3:0] cnt;
  logic [7:0] shreg;
  logic rw;
  logic first;
  logic more;
  logic scl_hold;
  logic sda_low;
  logic tx_rdy;
  logic wake;
  logic active;
  logic notify;
  logic rx_out_valid;
  nhisp_rx_s rx_in;
  nhisp_rx_s rx_out;
  logic rx_in_ready;

  // Line events from the filtered levels
  wire scl_rise = scl_f & ~scl_p;
  wire scl_fall = ~scl_f & scl_p;
  wire bus_start = scl_f & scl_p & sda_p & ~sda_f;
  wire bus_stop = scl_f & scl_p & ~sda_p & sda_f;
  wire byte_done = (cnt == NHISP_BYTE_BITS);
  // Seven-bit compare only; general call and 10-bit headers never match
  wire addr_hit = (shreg[7:1] == {NHISP_ADDR_HEADER, strap});
  // Gated like the engine, so a wake never leaves without its acknowledge
  wire addr_take = BUS_SELECT && strap_done && (state == ST_ADDR) && scl_fall && byte_done && addr_hit;
  wire rx_push = (state == ST_WR_HOLD) && rx_in_ready;
  wire tx_take = tx_rdy & TX_VALID;

  assign rx_in.first = first;
  assign rx_in.data = shreg;

  // Three-stage sampling; a level moves only when stages two and three agree.
  // With a 50 MHz clock the 3.4 MHz half period still spans several samples.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      scl_f <= 1'b1;
      sda_f <= 1'b1;
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_s <= {scl_s[1:0], SERIAL_CLOCK_PIN_I};
      sda_s <= {sda_s[1:0], SERIAL_DATA_PIN_I};
      if (scl_s[1] == scl_s[2]) scl_f <= scl_s[2];
      if (sda_s[1] == sda_s[2]) sda_f <= sda_s[2];
      scl_p <= scl_f;
      sda_p <= sda_f;
    end
  end

  // Straps are static; caught once on the first edge after reset release
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      strap <= 2'h0;
      strap_done <= 1'b0;
    end else if (!strap_done) begin
      strap <= {ADDR_STRAP_BIT1, ADDR_STRAP_BIT0};
      strap_done <= 1'b1;
    end
  end

  // Byte engine: shift on rising clock, change data after falling clock
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state <= ST_IDLE;
      cnt <= 4'h0;
      shreg <= 8'h00;
      rw <= 1'b0;
      first <= 1'b0;
      more <= 1'b0;
      scl_hold <= 1'b0;
      sda_low <= 1'b0;
      tx_rdy <= 1'b0;
    end else if (!BUS_SELECT || !strap_done || bus_stop) begin
      state <= ST_IDLE;
      scl_hold <= 1'b0;
      sda_low <= 1'b0;
      tx_rdy <= 1'b0;
    end else if (bus_start) begin
      // Repeated start also lands here, which covers high-speed entry
      state <= ST_ADDR;
      cnt <= 4'h0;
      first <= 1'b1;
      scl_hold <= 1'b0;
      sda_low <= 1'b0;
      tx_rdy <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
        end
        ST_ADDR: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda_f};
            cnt <= cnt + 4'h1;
          end else if (scl_fall && byte_done) begin
            if (addr_hit) begin
              sda_low <= 1'b1;
              rw <= shreg[0];
              state <= ST_ADDR_ACK;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            sda_low <= 1'b0;
            cnt <= 4'h0;
            if (rw) begin
              state <= ST_RD_LOAD;
              scl_hold <= 1'b1;
              tx_rdy <= 1'b1;
            end else begin
              state <= ST_WR_DATA;
            end
          end
        end
        ST_WR_DATA: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda_f};
            cnt <= cnt + 4'h1;
          end else if (scl_fall && byte_done) begin
            state <= ST_WR_HOLD;
            scl_hold <= 1'b1;
          end
        end
        ST_WR_HOLD: begin
          // Clock stays low until the buffer takes the byte
          if (rx_in_ready) begin
            sda_low <= 1'b1;
            state <= ST_WR_ACK;
          end
        end
        ST_WR_ACK: begin
          // Clock freed a cycle after the acknowledge, so data settles while low
          scl_hold <= 1'b0;
          if (scl_fall) begin
            sda_low <= 1'b0;
            first <= 1'b0;
            cnt <= 4'h0;
            state <= ST_WR_DATA;
          end
        end
        ST_RD_LOAD: begin
          if (tx_take) begin
            shreg <= TX_DATA;
            sda_low <= ~TX_DATA[7];
            tx_rdy <= 1'b0;
            cnt <= 4'h0;
            state <= ST_RD_DATA;
          end
        end
        ST_RD_DATA: begin
          // First bit is driven while still stretching; release one cycle later
          scl_hold <= 1'b0;
          if (scl_fall) begin
            if (cnt == NHISP_BYTE_BITS - 4'h1) begin
              sda_low <= 1'b0;
              state <= ST_RD_ACK;
            end else begin
              shreg <= {shreg[6:0], 1'b0};
              sda_low <= ~shreg[6];
              cnt <= cnt + 4'h1;
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            more <= ~sda_f;
          end else if (scl_fall) begin
            // A not-acknowledge ends reading until the next start
            if (more) begin
              state <= ST_RD_LOAD;
              scl_hold <= 1'b1;
              tx_rdy <= 1'b1;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Wake pulse and power state; a wake beats a standby request
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      wake <= 1'b0;
      active <= 1'b1;
    end else begin
      wake <= addr_take;
      if (addr_take) active <= 1'b1;
      else if (STANDBY_REQ) active <= 1'b0;
    end
  end

  // Notify the host of waiting read data at the programmed level while selected; deselected holds the pin low
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      notify <= 1'b0;
    end else begin
      notify <= BUS_SELECT & (TX_VALID ^ ~NOTIFY_ACTIVE_HIGH);
    end
  end

  // Receive buffer; a full buffer stretches the clock through rx_in_ready
  nhisp_fifo #(
    .WIDTH(NHISP_RX_W),
    .DEPTH(NHISP_FIFO_DEPTH)
  ) u_rx_fifo (
    .CLK(CLK),
    .RSTN(RSTN),
    .in_valid(rx_push),
    .in_ready(rx_in_ready),
    .in_data(rx_in),
    .out_valid(rx_out_valid),
    .out_ready(RX_READY),
    .out_data(rx_out)
  );

  // Open-drain: the output level is always low, only enables move
  assign SERIAL_CLOCK_PIN_O = 1'b0;
  assign SERIAL_DATA_PIN_O = 1'b0;
  assign SERIAL_CLOCK_PIN_OE = scl_hold;
  assign SERIAL_DATA_PIN_OE = sda_low;
  assign NOTIFY_PIN = notify;
  assign WAKE = wake;
  assign ACTIVE = active;
  assign TX_READY = tx_rdy;
  assign RX_VALID = rx_out_valid;
  assign RX_FIRST = rx_out.first;
  assign RX_DATA = rx_out.data;

endmodule // nhisp_slave

//--- sim/nhisp_slave_chk.sv
`timescale 1ns/1ps
module nhisp_slave_chk
  import nhisp_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // Bus pins
  input wire logic SERIAL_CLOCK_PIN_I,
  input wire logic SERIAL_CLOCK_PIN_O,
  input wire logic SERIAL_CLOCK_PIN_OE,
  input wire logic SERIAL_DATA_PIN_O,
  input wire logic SERIAL_DATA_PIN_OE,
  // Config, notify and power
  input wire logic BUS_SELECT,
  input wire logic NOTIFY_ACTIVE_HIGH,
  input wire logic NOTIFY_PIN,
  input wire logic WAKE,
  input wire logic ACTIVE,
  // Streams
  input wire logic RX_VALID,
  input wire logic RX_READY,
  input wire logic [NHISP_DATA_W-1:0] RX_DATA,
  input wire logic TX_VALID,
  input wire logic TX_READY
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // Notify is pending data at the chosen level, a cycle late
  property p_notify; $past(RSTN) && BUS_SELECT && $past(BUS_SELECT) |->
    NOTIFY_PIN == ($past(TX_VALID) ~^ $past(NOTIFY_ACTIVE_HIGH)); endproperty
  a_notify: assert property (p_notify) else $error("notify level wrong");
  property p_sel_off; !BUS_SELECT && $past(!BUS_SELECT) |-> !SERIAL_DATA_PIN_OE && !SERIAL_CLOCK_PIN_OE && !WAKE;
  endproperty
  a_sel_off: assert property (p_sel_off) else $error("bus active while deselected");
  property p_wake_pulse; WAKE |=> !WAKE; endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake longer than one cycle");
  property p_wake_act; WAKE |-> ##[0:1] ACTIVE; endproperty
  a_wake_act: assert property (p_wake_act) else $error("wake did not activate");
  // Wake only comes with the address acknowledge driven
  property p_ack_wake; WAKE |-> SERIAL_DATA_PIN_OE; endproperty
  a_ack_wake: assert property (p_ack_wake) else $error("wake without acknowledge");
  property p_od; SERIAL_CLOCK_PIN_O == 1'b0 && SERIAL_DATA_PIN_O == 1'b0; endproperty
  a_od: assert property (p_od) else $error("pin driven high");
  property p_tx_stretch; TX_READY |-> SERIAL_CLOCK_PIN_OE; endproperty
  a_tx_stretch: assert property (p_tx_stretch) else $error("no stretch while waiting data");
  property p_tx_hold; TX_READY && !TX_VALID |=> TX_READY; endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("ready dropped untaken");
  property p_rx_hold; RX_VALID && !RX_READY |=> RX_VALID && $stable(RX_DATA); endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx byte not held");
  // Data line only moves while the clock is low
  property p_sda_low; $changed(SERIAL_DATA_PIN_OE) |-> !SERIAL_CLOCK_PIN_I; endproperty
  a_sda_low: assert property (p_sda_low) else $error("data moved with clock high");
  c_wake: cover property (WAKE);
  c_rx: cover property (RX_VALID && RX_READY);
  c_tx: cover property (TX_VALID && TX_READY);
endmodule // nhisp_slave_chk

bind nhisp_slave nhisp_slave_chk nhisp_slave_chk_inst (.*);

//--- sim/nhisp_host_model.sv
`timescale 1ns/1ps
module nhisp_host_model (
  // Wire levels
  input wire logic scl,
  input wire logic sda,
  // Pull-low enables
  output logic scl_oe,
  output logic sda_oe
);
  // Stretches that outlasted the wait limit
  int stalls = 0;
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end
  // Release clock, wait out any stretch, hold high 40 ns
  task automatic half_hi();
    int n = 0;
    scl_oe = 1'b0;
    while (scl !== 1'b1 && n < 5000) begin
      #10;
      n++;
    end
    if (n >= 5000) stalls++;
    #40;
  endtask
  // One bit: low time 120 ns keeps the slave's sampler ahead
  task automatic bit_x(input logic b, output logic r);
    sda_oe = !b;
    #60;
    half_hi();
    r = sda;
    scl_oe = 1'b1;
    #60;
  endtask
  task automatic start();
    sda_oe = 1'b0;
    scl_oe = 1'b0;
    #100;
    sda_oe = 1'b1;
    #100;
    scl_oe = 1'b1;
    #60;
  endtask
  task automatic stop();
    sda_oe = 1'b1;
    #60;
    half_hi();
    #100;
    sda_oe = 1'b0;
    #100;
  endtask
  // Byte MSB first, then ninth bit; send 8'hff to read
  task automatic xfer(input logic [7:0] d, input logic a_in, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], q[i]);
    end
    bit_x(a_in, a);
  endtask
endmodule // nhisp_host_model

//--- sim/test_nhisp_slave.sv
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fails++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_nhisp_slave;
  import nhisp_pkg::*;
  logic clk = 0, rstn = 0, bsel = 1, nah = 1, stby = 0, rx_ready = 0, tx_valid = 0, woke = 0, st0 = 0, st1 = 1;
  logic [NHISP_DATA_W-1:0] tx_data = 8'h00, q, rx_data;
  logic scl_oe, sda_oe, scl_o, scl_e, sda_o, sda_e, rx_valid, rx_first, tx_ready, notify, wake, active, ack;
  int fails = 0, comparisons = 0;
  // Open-drain wires with pull-ups
  wire scl = !(scl_oe | scl_e);
  wire sda = !(sda_oe | sda_e);
  always #10 clk = ~clk;
  // Remember any wake pulse
  always @(posedge clk) if (wake === 1'b1) woke <= 1'b1;
  nhisp_slave nhisp_slave_inst (.CLK(clk), .RSTN(rstn), .SERIAL_CLOCK_PIN_I(scl), .SERIAL_CLOCK_PIN_O(scl_o),
    .SERIAL_CLOCK_PIN_OE(scl_e), .SERIAL_DATA_PIN_I(sda), .SERIAL_DATA_PIN_O(sda_o), .SERIAL_DATA_PIN_OE(sda_e),
    .ADDR_STRAP_BIT0(st0), .ADDR_STRAP_BIT1(st1), .BUS_SELECT(bsel), .NOTIFY_ACTIVE_HIGH(nah),
    .NOTIFY_PIN(notify), .STANDBY_REQ(stby), .WAKE(wake), .ACTIVE(active), .RX_VALID(rx_valid),
    .RX_READY(rx_ready), .RX_FIRST(rx_first), .RX_DATA(rx_data), .TX_VALID(tx_valid), .TX_READY(tx_ready),
    .TX_DATA(tx_data));
  nhisp_host_model nhisp_host_model_inst (.scl(scl), .sda(sda), .scl_oe(scl_oe), .sda_oe(sda_oe));
  task automatic addr(input logic [7:0] a);
    nhisp_host_model_inst.start();
    nhisp_host_model_inst.xfer(a, 1'b1, q, ack);
  endtask
  // Other slaves, general call and mode code stay unanswered
  task automatic t_foreign();
    logic [7:0] list [4] = '{8'h50, 8'h00, 8'h56, 8'h08};
    woke = 0;
    foreach (list[i]) begin
      addr(list[i]);
      `CHK(ack, 1'b1)
      nhisp_host_model_inst.stop();
    end
    `CHK(woke, 1'b0)
  endtask
  task automatic drain(input logic [7:0] d, input logic f);
    int n = 0;
    while (rx_valid !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    `CHK(rx_data, d)
    `CHK(rx_first, f)
    `CHK(n < 2000, 1'b1)
    rx_ready = 1;
    @(negedge clk) rx_ready = 0;
    @(negedge clk);
  endtask
  // Standby, wake on own address, fill FIFO past full
  task automatic t_write();
    @(negedge clk) stby = 1;
    @(negedge clk) stby = 0;
    @(negedge clk) `CHK(active, 1'b0)
    woke = 0;
    addr(8'h54);
    `CHK(ack, 1'b0)
    `CHK(woke, 1'b1)
    `CHK(active, 1'b1)
    fork
      for (int i = 0; i < 5; i++) begin
        nhisp_host_model_inst.xfer(8'(8'ha0 + i), 1'b1, q, ack);
        `CHK(ack, 1'b0)
      end
      begin
        repeat (600) @(negedge clk);
        `CHK(scl_e, 1'b1)
        for (int i = 0; i < 5; i++) drain(8'(8'ha0 + i), i == 0);
      end
    join
    nhisp_host_model_inst.stop();
  endtask
  task automatic supply(input logic [7:0] d);
    int n = 0;
    @(negedge clk) tx_valid = 1;
    tx_data = d;
    while (tx_ready !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    // Byte taken at the rising edge just passed; release only now
    @(negedge clk) `CHK(notify, 1'b1)
    `CHK(tx_ready, 1'b0)
    `CHK(n < 2000, 1'b1)
    tx_valid = 0;
  endtask
  // Read two bytes, ack then nack, device stretching for data
  task automatic t_read();
    logic [7:0] r0, r1;
    addr(8'h55);
    `CHK(ack, 1'b0)
    fork
      begin
        nhisp_host_model_inst.xfer(8'hff, 1'b0, r0, ack);
        nhisp_host_model_inst.xfer(8'hff, 1'b1, r1, ack);
        nhisp_host_model_inst.stop();
      end
      begin
        supply(8'h3c);
        supply(8'hc5);
      end
    join
    `CHK(r0, 8'h3c)
    `CHK(r1, 8'hc5)
  endtask
  // Both levels, pending and not
  task automatic t_notify();
    for (int i = 0; i < 4; i++) begin
      @(negedge clk) nah = i[1];
      tx_valid = i[0];
      repeat (2) @(negedge clk);
      `CHK(notify, 1'(i[0] == i[1]))
    end
    @(negedge clk) nah = 1;
    tx_valid = 0;
  endtask
  task automatic t_bus_off();
    @(negedge clk) bsel = 0;
    woke = 0;
    addr(8'h54);
    `CHK(ack, 1'b1)
    nhisp_host_model_inst.stop();
    `CHK(woke, 1'b0)
    @(negedge clk) bsel = 1;
  endtask
  // Mid-run reset with new straps; only the new address answers
  task automatic t_reset();
    @(negedge clk) rstn = 0;
    st0 = 1;
    repeat (3) @(negedge clk);
    `CHK(active, 1'b1)
    `CHK(scl_e | sda_e | tx_ready | rx_valid | wake, 1'b0)
    rstn = 1;
    repeat (2) @(negedge clk);
    `CHK(scl_e | sda_e | wake | notify, 1'b0)
    repeat (3) @(negedge clk);
    woke = 0;
    addr(8'h56);
    `CHK(ack, 1'b0)
    nhisp_host_model_inst.stop();
    `CHK(woke, 1'b1)
    addr(8'h54);
    `CHK(ack, 1'b1)
    nhisp_host_model_inst.stop();
  endtask
  task automatic stop_test();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (3) @(negedge clk);
    rstn = 1;
    repeat (5) @(negedge clk);
    t_foreign();
    t_write();
    t_read();
    t_notify();
    t_bus_off();
    t_reset();
    `CHK(nhisp_host_model_inst.stalls, 0)
    stop_test();
  end
  // Watchdog, well past the expected run
  initial begin
    #400000;
    fails++;
    stop_test();
  end
endmodule // test_nhisp_slave
